/* File: core/ibs_pkg.sv */
package ibs_pkg;

    // ------------------------------------------------------------------
    // widths and fixed bus values
    // ------------------------------------------------------------------
    localparam int          ADDR_W     = 16;
    localparam int          DATA_W     = 8;
    localparam logic [15:0] DUMMY_ADDR = 16'hFFFF;  // address of every dummy cycle
    localparam logic [7:0]  CLEAR_DATA = 8'h00;     // byte written by a clear
    localparam logic [7:0]  IDLE_DATA  = 8'h00;
    localparam logic [2:0]  LAST_SLOT  = 3'h6;      // seven slots per sequence

    // ------------------------------------------------------------------
    // bus cycle kinds
    // ------------------------------------------------------------------
    localparam logic [3:0] K_IMM  = 4'h0;  // immediate byte fetch
    localparam logic [3:0] K_OFS  = 4'h1;  // offset byte fetch
    localparam logic [3:0] K_AHI  = 4'h2;  // address high byte fetch
    localparam logic [3:0] K_ALO  = 4'h3;  // address low byte fetch
    localparam logic [3:0] K_DUM  = 4'h4;  // dummy cycle
    localparam logic [3:0] K_RD   = 4'h5;  // operand read at ea
    localparam logic [3:0] K_RD1  = 4'h6;  // operand read at ea+1
    localparam logic [3:0] K_WR   = 4'h7;  // write at ea
    localparam logic [3:0] K_WR1  = 4'h8;  // write at ea+1
    localparam logic [3:0] K_WR0  = 4'h9;  // write of zero at ea
    localparam logic [3:0] K_PLO  = 4'hA;  // push return low byte
    localparam logic [3:0] K_PHI  = 4'hB;  // push return high byte
    localparam logic [3:0] K_NXT  = 4'hC;  // next opcode fetch
    localparam logic [3:0] K_NONE = 4'hF;  // slot unused

    // ------------------------------------------------------------------
    // sequence lengths in cycles
    // ------------------------------------------------------------------
    localparam logic [2:0] LEN_JMP  = 3'h3;
    localparam logic [2:0] LEN_RD8  = 3'h4;
    localparam logic [2:0] LEN_ST8  = 3'h4;
    localparam logic [2:0] LEN_W16  = 3'h5;
    localparam logic [2:0] LEN_JSRX = 3'h5;
    localparam logic [2:0] LEN_JSRE = 3'h6;
    localparam logic [2:0] LEN_RMW  = 3'h6;
    localparam logic [2:0] LEN_TIM  = 3'h5;
    localparam logic [2:0] LEN_CLR  = 3'h5;
    localparam logic [2:0] LEN_IMMW = 3'h7;

    // ------------------------------------------------------------------
    // instruction classes and carriers
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        C_JMP, C_RD8, C_ST8, C_RD16, C_ST16, C_JSR, C_RMW, C_TIM, C_CLR, C_IMMW
    } ibs_cls_t;

    typedef struct packed {
        ibs_cls_t    cls;      // instruction class
        logic        ext;      // 1 extended, 0 indexed
        logic [15:0] op_addr;  // address of the opcode byte
        logic [15:0] index_register;
        logic [15:0] sp;       // stack pointer
        logic [7:0]  acc;      // accumulator for 8-bit stores
        logic [15:0] reg16;    // register for 16-bit stores
    } ibs_req_t;

    typedef struct packed {
        logic [15:0] addr;
        logic        rw;       // 1 read, 0 write
        logic        rd_n;
        logic        wr_n;
        logic        opcode_fetch_indicator_n;
        logic [7:0]  dout;
    } ibs_bus_t;

    localparam ibs_bus_t BUS_IDLE = '{DUMMY_ADDR, 1'b1, 1'b1, 1'b1, 1'b1, IDLE_DATA};

    // expected length of a legal sequence
    function automatic logic [2:0] ibs_len(input ibs_cls_t c, input logic e);
        unique case (c)
            C_JMP:   ibs_len = LEN_JMP;
            C_RD8:   ibs_len = LEN_RD8;
            C_ST8:   ibs_len = LEN_ST8;
            C_RD16:  ibs_len = LEN_W16;
            C_ST16:  ibs_len = LEN_W16;
            C_JSR:   ibs_len = e ? LEN_JSRE : LEN_JSRX;
            C_RMW:   ibs_len = LEN_RMW;
            C_TIM:   ibs_len = LEN_TIM;
            C_CLR:   ibs_len = LEN_CLR;
            default: ibs_len = LEN_IMMW;
        endcase
    endfunction

endpackage

/* File: core/ibs_seq_rom.sv */
`timescale 1ns/1ps
module ibs_seq_rom import ibs_pkg::*; (
    input  ibs_cls_t   cls,
    input  logic       ext,
    input  logic [2:0] slot,
    output logic [3:0] kind
);

    // ------------------------------------------------------------------
    // cycle list per class, first cycle in the top slot
    // ------------------------------------------------------------------
    function automatic logic [6:0][3:0] seq_of(input ibs_cls_t c, input logic e);
        logic [3:0] a0;
        logic [3:0] a1;
        a0 = e ? K_AHI : K_OFS;
        a1 = e ? K_ALO : K_DUM;
        seq_of = {7{K_NONE}};
        unique case (c)
            C_JMP:  seq_of = {a0, a1, K_NXT, {4{K_NONE}}};
            C_RD8:  seq_of = {a0, a1, K_RD, K_NXT, {3{K_NONE}}};
            C_ST8:  seq_of = {a0, a1, K_WR, K_NXT, {3{K_NONE}}};
            C_RD16: seq_of = {a0, a1, K_RD, K_RD1, K_NXT, {2{K_NONE}}};
            C_ST16: seq_of = {a0, a1, K_WR, K_WR1, K_NXT, {2{K_NONE}}};
            C_JSR:  seq_of = e ? {a0, a1, K_DUM, K_PLO, K_PHI, K_NXT, K_NONE}
                               : {a0, a1, K_PLO, K_PHI, K_NXT, {2{K_NONE}}};
            C_RMW:  seq_of = {a0, a1, K_RD, K_DUM, K_WR, K_NXT, K_NONE};  // RULE_07 RULE_17
            C_CLR:  seq_of = {a0, a1, K_RD, K_WR0, K_NXT, {2{K_NONE}}};  // RULE_09 RULE_18
            C_TIM:  seq_of = e ? {7{K_NONE}}
                               : {K_IMM, K_OFS, K_DUM, K_RD, K_NXT, {2{K_NONE}}};
            C_IMMW: seq_of = e ? {7{K_NONE}}
                               : {K_IMM, K_OFS, K_DUM, K_RD, K_DUM, K_WR, K_NXT};
            default: seq_of = {7{K_NONE}};
        endcase
    endfunction

    // ------------------------------------------------------------------
    // slot select
    // ------------------------------------------------------------------
    logic [6:0][3:0] seq;

    // table lookup for the requested slot
    always_comb begin
        seq  = seq_of(cls, ext);
        kind = seq[LAST_SLOT - slot];
    end

endmodule

/* File: core/ibs_bus_gen.sv */
`timescale 1ns/1ps
module ibs_bus_gen import ibs_pkg::*; (
    input  logic [3:0]  kind,
    input  ibs_cls_t    cls,
    input  logic [15:0] pc,
    input  logic [15:0] ea,
    input  logic [15:0] sp,
    input  logic [7:0]  acc,
    input  logic [15:0] reg16,
    input  logic [7:0]  new_data,
    output ibs_bus_t    bus
);

    // ------------------------------------------------------------------
    // one bus cycle from its kind
    // ------------------------------------------------------------------
    logic [15:0] ea_p1;
    logic        jumps;

    assign ea_p1 = ea + 16'h0001;
    assign jumps = (cls == C_JMP) || (cls == C_JSR);

    // address, strobes and write data per cycle kind
    always_comb begin
        bus = BUS_IDLE;
        unique case (kind)
            K_IMM, K_OFS, K_AHI, K_ALO: begin
                bus.addr = pc;
                bus.rd_n = 1'b0;
            end
            K_DUM: bus = BUS_IDLE;  // all strobes high at the dummy address
            K_RD: begin
                bus.addr = ea;
                bus.rd_n = 1'b0;
            end
            K_RD1: begin
                bus.addr = ea_p1;
                bus.rd_n = 1'b0;
            end
            K_WR: begin
                bus.addr = ea;
                bus.rw   = 1'b0;
                bus.wr_n = 1'b0;
                bus.dout = (cls == C_ST8) ? acc : (cls == C_ST16) ? reg16[15:8] : new_data;
            end
            K_WR1: begin
                bus.addr = ea_p1;
                bus.rw   = 1'b0;
                bus.wr_n = 1'b0;
                bus.dout = reg16[7:0];
            end
            K_WR0: begin
                bus.addr = ea;
                bus.rw   = 1'b0;
                bus.wr_n = 1'b0;
                bus.dout = CLEAR_DATA;
            end
            K_PLO: begin
                bus.addr = sp;
                bus.rw   = 1'b0;
                bus.wr_n = 1'b0;
                bus.dout = pc[7:0];
            end
            K_PHI: begin
                bus.addr = sp - 16'h0001;
                bus.rw   = 1'b0;
                bus.wr_n = 1'b0;
                bus.dout = pc[15:8];
            end
            K_NXT: begin
                bus.addr                     = jumps ? ea : pc;
                bus.rd_n                     = 1'b0;
                bus.opcode_fetch_indicator_n = 1'b0;
            end
            default: bus = BUS_IDLE;
        endcase
    end

endmodule

/* File: core/ibs_sequencer.sv */
`timescale 1ns/1ps
// How it works
// [RULE_01] indexed jump: offset, dummy, target fetch
// [RULE_02] indexed reads: offset, dummy, read, next
// [RULE_03] indexed accumulator store writes at third cycle
// [RULE_04] indexed word reads: high byte, then low
// [RULE_05] indexed word stores write high then low
// [RULE_06] indexed call pushes low, high, fetches target
// [RULE_07] indexed modify: read, dummy, write back, next
// [RULE_08] indexed bit test reads and never writes
// [RULE_09] indexed clear: read then write zero directly
// [RULE_10] indexed immediate logic ops take seven cycles
// [RULE_11] extended jump: two address bytes, target fetch
// [RULE_12] extended reads: two address bytes, read
// [RULE_13] extended accumulator store writes after address
// [RULE_14] extended word reads at address, address+1
// [RULE_15] extended word stores high then low byte
// [RULE_16] extended call: address, dummy, push, target
// [RULE_17] extended modify: read, dummy, write back
// [RULE_18] extended clear: read then write zero
// [RULE_19] fetch indicator low only last; dummies idle
module ibs_sequencer import ibs_pkg::*; (
    input  logic        mclk,
    input  logic        rst,
    input  logic        start,
    input  ibs_req_t    req,
    input  logic [7:0]  new_data,
    input  logic [7:0]  din,
    output ibs_bus_t    bus,
    output logic        busy,
    output logic        done,
    output logic        refused,
    output logic [15:0] operand,
    output logic [7:0]  imm_data
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef enum logic {ST_IDLE, ST_RUN} ibs_state_t;

    ibs_state_t  state_q;
    ibs_req_t    req_q;
    ibs_req_t    ctx;
    ibs_bus_t    bus_d;
    logic [2:0]  slot_q;
    logic [2:0]  slot_nx;
    logic [3:0]  kind_q;
    logic [3:0]  kind_nx;
    logic [3:0]  kind_first;
    logic [15:0] pc_q;
    logic [15:0] pc_cur;
    logic [7:0]  ofs_q;
    logic [7:0]  ahi_q;
    logic [7:0]  alo_q;
    logic [7:0]  ofs_live;
    logic [7:0]  ahi_live;
    logic [7:0]  alo_live;
    logic [15:0] ea;
    logic [15:0] opnd_q;
    logic [7:0]  imm_q;
    logic [2:0]  cyc_q;
    logic        idle;
    logic        accept;
    logic        last;
    logic        fetch_nx;

    assign idle    = (state_q == ST_IDLE);
    assign ctx     = idle ? req : req_q;
    assign slot_nx = idle ? 3'h0 : slot_q + 3'h1;
    assign last    = !idle && (kind_q == K_NXT);

    // ------------------------------------------------------------------
    // sequence table lookups
    // ------------------------------------------------------------------
    ibs_seq_rom u_rom_next (
        .cls  (ctx.cls),
        .ext  (ctx.ext),
        .slot (slot_nx),
        .kind (kind_nx)
    );

    ibs_seq_rom u_rom_first (
        .cls  (req.cls),
        .ext  (req.ext),
        .slot (3'h0),
        .kind (kind_first)
    );

    // start only on a class that has a sequence in this mode
    assign accept  = idle && start && (kind_first != K_NONE);
    assign refused = idle && start && (kind_first == K_NONE);
    assign busy    = !idle;
    assign done    = last;

    // ------------------------------------------------------------------
    // effective address from bytes captured so far
    // ------------------------------------------------------------------
    // the byte fetched in the cycle now ending is used at once
    assign ofs_live = (!idle && kind_q == K_OFS) ? din : ofs_q;
    assign ahi_live = (!idle && kind_q == K_AHI) ? din : ahi_q;
    assign alo_live = (!idle && kind_q == K_ALO) ? din : alo_q;
    assign pc_cur   = idle ? req.op_addr + 16'h0001 : pc_q;

    // indexed: index plus unsigned offset; extended: fetched address
    always_comb begin
        if (ctx.ext) begin
            ea = {ahi_live, alo_live};  // RULE_12
        end else begin
            ea = ctx.index_register + {8'h00, ofs_live};  // RULE_02
        end
    end

    assign fetch_nx = (kind_nx == K_IMM) || (kind_nx == K_OFS) ||
                      (kind_nx == K_AHI) || (kind_nx == K_ALO);

    // ------------------------------------------------------------------
    // next bus cycle
    // ------------------------------------------------------------------
    ibs_bus_gen u_gen (
        .kind     (kind_nx),
        .cls      (ctx.cls),
        .pc       (pc_cur),
        .ea       (ea),
        .sp       (ctx.sp),
        .acc      (ctx.acc),
        .reg16    (ctx.reg16),
        .new_data (new_data),
        .bus      (bus_d)
    );

    // ------------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------------
    // run from accept until the next opcode fetch has ended
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            slot_q  <= 3'h0;
            kind_q  <= K_NONE;
        end else if (accept) begin
            state_q <= ST_RUN;
            slot_q  <= 3'h0;
            kind_q  <= kind_nx;
        end else if (last) begin
            state_q <= ST_IDLE;  // RULE_19
            slot_q  <= 3'h0;
            kind_q  <= K_NONE;
        end else if (!idle) begin
            slot_q  <= slot_nx;
            kind_q  <= kind_nx;
        end
    end

    // request held for the whole sequence
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            req_q <= '0;
        end else if (accept) begin
            req_q <= req;
        end
    end

    // registered bus outputs, idle between sequences
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bus <= BUS_IDLE;
        end else if (accept || (!idle && !last)) begin
            bus <= bus_d;  // RULE_01 RULE_03 RULE_05 RULE_06 RULE_13 RULE_15 RULE_16
        end else begin
            bus <= BUS_IDLE;
        end
    end

    // program counter advances past each fetched instruction byte
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pc_q <= 16'h0000;
        end else if (accept || !idle) begin
            pc_q <= fetch_nx ? pc_cur + 16'h0001 : pc_cur;  // RULE_11
        end
    end

    // ------------------------------------------------------------------
    // data capture
    // ------------------------------------------------------------------
    // instruction bytes taken at the end of their fetch cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ofs_q <= 8'h00;
            ahi_q <= 8'h00;
            alo_q <= 8'h00;
            imm_q <= 8'h00;
        end else if (!idle) begin
            if (kind_q == K_OFS) begin
                ofs_q <= din;
            end
            if (kind_q == K_AHI) begin
                ahi_q <= din;
            end
            if (kind_q == K_ALO) begin
                alo_q <= din;
            end
            if (kind_q == K_IMM) begin
                imm_q <= din;  // RULE_08 RULE_10
            end
        end
    end

    // operand shifts in high byte first
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            opnd_q <= 16'h0000;
        end else if (accept) begin
            opnd_q <= 16'h0000;
        end else if (!idle && (kind_q == K_RD || kind_q == K_RD1)) begin
            opnd_q <= {opnd_q[7:0], din};  // RULE_04 RULE_14
        end
    end

    assign operand  = opnd_q;
    assign imm_data = imm_q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    // cycle count helper: cycles driven in the current sequence
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cyc_q <= 3'h0;
        end else if (accept) begin
            cyc_q <= 3'h1;
        end else if (!idle && !last) begin
            cyc_q <= cyc_q + 3'h1;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    seq_length_a: assert property (done |-> cyc_q == ibs_len(req_q.cls, req_q.ext)) // RULE_01
        else $error("sequence length differs from its class");

    dummy_idle_a: assert property (!idle && kind_q == K_DUM |-> // RULE_19
        bus.addr == DUMMY_ADDR && bus.rw && bus.rd_n && bus.wr_n)
        else $error("dummy cycle not idle at the dummy address");

    fetch_last_a: assert property (!idle |-> (!bus.opcode_fetch_indicator_n == last)) // RULE_19
        else $error("fetch indicator low outside the final cycle");

    write_level_a: assert property (!bus.wr_n |-> !bus.rw && bus.rd_n) // RULE_03
        else $error("write strobe without write level");

    clear_zero_a: assert property (!idle && kind_q == K_WR0 |-> // RULE_09
        bus.dout == CLEAR_DATA && $past(kind_q) == K_RD && bus.addr == $past(bus.addr))
        else $error("clear did not write zero right after its read");

    rmw_same_addr_a: assert property (!idle && kind_q == K_WR && req_q.cls == C_RMW |-> // RULE_07
        $past(kind_q) == K_DUM && bus.addr == $past(bus.addr, 2))
        else $error("modify write not at the operand address");

    word_next_a: assert property (!idle && (kind_q == K_RD1 || kind_q == K_WR1) |-> // RULE_04
        bus.addr == $past(bus.addr) + 16'h0001)
        else $error("second byte not at the next address");

    push_order_a: assert property (!idle && kind_q == K_PLO |-> // RULE_06
        ##1 (kind_q == K_PHI && bus.addr == $past(bus.addr) - 16'h0001)
        ##1 (kind_q == K_NXT && bus.addr == $past(ea, 2)))
        else $error("return push or target fetch out of order");

    test_no_write_a: assert property (!idle && req_q.cls == C_TIM |-> bus.wr_n) // RULE_08
        else $error("bit test wrote memory");

    ext_jump_a: assert property (accept && req.ext && req.cls == C_JMP |-> // RULE_11
        ##1 !bus.rd_n [*3] ##0 !bus.opcode_fetch_indicator_n)
        else $error("extended jump inserted a dummy cycle");

    // byte stored by an accumulator store is the held accumulator
    store_acc_a: assert property (!idle && kind_q == K_WR && req_q.cls == C_ST8 |-> // RULE_03
        bus.dout == req_q.acc)
        else $error("accumulator store wrote another byte");

    // immediate logic op writes back where it read, after a dummy
    imm_write_a: assert property (!idle && kind_q == K_WR && req_q.cls == C_IMMW |-> // RULE_10
        $past(kind_q) == K_DUM && bus.addr == $past(bus.addr, 2) &&
        bus.dout == $past(new_data))
        else $error("immediate logic write not at the operand address");

    // one idle bus cycle always follows the final fetch
    end_idle_a: assert property (done |=> !busy && bus == BUS_IDLE) // RULE_19
        else $error("bus not idle after the final fetch");

    // extended store writes straight after the two address bytes
    ext_store_a: assert property (accept && req.ext && req.cls == C_ST8 |-> // RULE_13
        ##3 (!bus.wr_n && !bus.rw) ##1 !bus.opcode_fetch_indicator_n)
        else $error("extended store write not in its third cycle");

    // main scenarios reached
    cover_imm_logic_c: cover property (accept && req.cls == C_IMMW ##7 done);
    cover_ext_call_c:  cover property (accept && req.ext && req.cls == C_JSR ##6 done);
    cover_idx_clear_c: cover property (accept && !req.ext && req.cls == C_CLR ##5 done);
    cover_ext_rmw_c:   cover property (accept && req.ext && req.cls == C_RMW ##6 done);
    cover_refused_c:   cover property (refused);

endmodule

/* File: tb/ibs_mem_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// memory on the far side of the sequencer bus
// ----------------------------------------------------------------
module ibs_mem_model import ibs_pkg::*; (
    input  wire logic     mclk,
    input  wire ibs_bus_t bus,
    output logic [7:0]    din
);
    logic [7:0] last_q = 8'h00;

    // a byte pattern tied to the address while the read strobe is low
    always_comb begin
        if (bus.rd_n == 1'b0) begin
            din = bus.addr[7:0] ^ 8'hA5;
        end else begin
            din = ~last_q;  // released line never shows the old byte
        end
    end

    // last driven value, so a released line keeps changing
    always_ff @(posedge mclk) begin
        last_q <= din;
    end
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top import ibs_pkg::*; ();
    // ----------------------------------------------------------------
    // stimulus, design and memory
    // ----------------------------------------------------------------
    localparam logic [15:0] A  = 16'h1230;
    localparam logic [15:0] X  = 16'h40F0;
    localparam logic [15:0] SP = 16'h0200;
    localparam logic [3:0]  R_ = 4'b1011;  // rw, rd_n, wr_n, fetch flag
    localparam logic [3:0]  N_ = 4'b1010;
    localparam logic [3:0]  D_ = 4'b1111;
    localparam logic [3:0]  W_ = 4'b0101;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        start = 1'b0;
    ibs_req_t    req = '{C_JMP, 1'b0, A, X, SP, 8'h3C, 16'hBEEF};
    logic [7:0]  new_data = 8'h96;
    logic [7:0]  din;
    ibs_bus_t    bus;
    logic        busy, done, refused;
    logic [15:0] operand, opr, e_a, n_a;
    logic [7:0]  imm_data, imm;
    ibs_bus_t    cap [1:8];
    logic        dn [1:8];
    int          mismatches = 0;
    int          tests_run = 0;
    int          cyc = 0;

    ibs_sequencer u_dut (.mclk(mclk), .rst(rst), .start(start), .req(req),
        .new_data(new_data), .din(din), .bus(bus), .busy(busy), .done(done),
        .refused(refused), .operand(operand), .imm_data(imm_data));
    ibs_mem_model u_mem (.mclk(mclk), .bus(bus), .din(din));

    // clock and hang limit
    always #2 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 2000) begin
            fail("timeout");
            print_verdict;
        end
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    function automatic logic [7:0] mb(input logic [15:0] a);
        return a[7:0] ^ 8'hA5;
    endfunction

    task fail(input string m);
        mismatches++;
        $display("MISMATCH t=%0t %s", $time, m);
    endtask

    task ck(input logic ok, input string m);
        tests_run++;
        if (ok !== 1'b1) fail(m);
    endtask

    // compare one captured bus cycle; data only on writes
    task cb(input int k, input logic [15:0] a, input logic [3:0] s, input logic [7:0] d = 8'h00);
        tests_run++;
        if (cap[k].addr !== a || {cap[k].rw, cap[k].rd_n, cap[k].wr_n,
            cap[k].opcode_fetch_indicator_n} !== s || (!s[3] && cap[k].dout !== d))
            fail($sformatf("cycle %0d addr %h", k, cap[k].addr));
    endtask

    // start one sequence and capture n cycles plus the idle one
    task run(input ibs_cls_t c, input logic e, input int n);
        @(posedge mclk);
        start   <= 1'b1;
        req.cls <= c;
        req.ext <= e;
        @(posedge mclk);
        start <= 1'b0;
        for (int k = 1; k <= n + 1; k++) begin
            @(negedge mclk);
            cap[k] = bus;
            dn[k]  = done;
            if (k == n) begin
                opr = operand;
                imm = imm_data;
            end
        end
        ck(dn[n] === 1'b1 && busy === 1'b0 && cap[n+1] === BUS_IDLE, "end");
        for (int k = 1; k < n; k++) begin
            ck(dn[k] === 1'b0 && cap[k].opcode_fetch_indicator_n === 1'b1, "flag");
        end
    endtask

    // check the address-gathering cycles and work out ea and next
    task pre(input logic e, input logic t);
        e_a = e ? {mb(A + 16'h1), mb(A + 16'h2)} : X + {8'h00, mb(A + 16'h1 + {15'h0, t})};
        n_a = A + 16'h2 + {15'h0, e | t};
        cb(1, A + 16'h1, R_);
        if (e || t) cb(2, A + 16'h2, R_);
        if (!e) cb(2 + t, DUMMY_ADDR, D_);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task t_jmp;
        for (int i = 0; i < 2; i++) begin
            run(C_JMP, i[0], 3);
            pre(i[0], 1'b0);
            cb(3, e_a, N_);
        end
        $display("test jump done");
    endtask

    task t_rd8;
        for (int i = 0; i < 2; i++) begin
            run(C_RD8, i[0], 4);
            pre(i[0], 1'b0);
            cb(3, e_a, R_);
            cb(4, n_a, N_);
            ck(opr === {8'h00, mb(e_a)}, "byte operand");
        end
        $display("test read8 done");
    endtask

    task t_st8;
        for (int i = 0; i < 2; i++) begin
            run(C_ST8, i[0], 4);
            pre(i[0], 1'b0);
            cb(3, e_a, W_, 8'h3C);
            cb(4, n_a, N_);
        end
        $display("test store8 done");
    endtask

    task t_w16;
        for (int i = 0; i < 2; i++) begin
            run(C_RD16, i[0], 5);
            pre(i[0], 1'b0);
            cb(3, e_a, R_);
            cb(4, e_a + 16'h1, R_);
            cb(5, n_a, N_);
            ck(opr === {mb(e_a), mb(e_a + 16'h1)}, "word operand");
            run(C_ST16, i[0], 5);
            cb(3, e_a, W_, 8'hBE);
            cb(4, e_a + 16'h1, W_, 8'hEF);
            cb(5, n_a, N_);
        end
        $display("test word done");
    endtask

    task t_jsr;
        for (int i = 0; i < 2; i++) begin
            run(C_JSR, i[0], 5 + i);
            pre(i[0], 1'b0);
            if (i == 1) cb(3, DUMMY_ADDR, D_);
            cb(3 + i, SP, W_, n_a[7:0]);
            cb(4 + i, SP - 16'h1, W_, n_a[15:8]);
            cb(5 + i, e_a, N_);
        end
        $display("test call done");
    endtask

    task t_rmw_clr;
        for (int i = 0; i < 2; i++) begin
            run(C_RMW, i[0], 6);
            pre(i[0], 1'b0);
            cb(3, e_a, R_);
            cb(4, DUMMY_ADDR, D_);
            cb(5, e_a, W_, 8'h96);
            cb(6, n_a, N_);
            run(C_CLR, i[0], 5);
            cb(3, e_a, R_);
            cb(4, e_a, W_, 8'h00);
            cb(5, n_a, N_);
        end
        $display("test modify done");
    endtask

    task t_imm;
        run(C_TIM, 1'b0, 5);
        pre(1'b0, 1'b1);
        cb(4, e_a, R_);
        cb(5, n_a, N_);
        ck(imm === mb(A + 16'h1), "immediate");
        run(C_IMMW, 1'b0, 7);
        pre(1'b0, 1'b1);
        cb(4, e_a, R_);
        cb(5, DUMMY_ADDR, D_);
        cb(6, e_a, W_, 8'h96);
        cb(7, n_a, N_);
        $display("test immediate done");
    endtask

    // extended forms without a sequence are turned away
    task t_refuse;
        for (int i = 0; i < 2; i++) begin
            @(posedge mclk);
            start   <= 1'b1;
            req.cls <= i ? C_IMMW : C_TIM;
            req.ext <= 1'b1;
            @(negedge mclk);
            ck(refused === 1'b1, "no refusal");
            @(posedge mclk);
            start <= 1'b0;
            @(negedge mclk);
            ck(busy === 1'b0 && bus === BUS_IDLE, "refused ran");
        end
        $display("test refuse done");
    endtask

    task print_verdict;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (7) @(posedge mclk);
        @(negedge mclk);
        ck(bus === BUS_IDLE && busy === 1'b0, "reset bus");
        @(posedge mclk);
        rst <= 1'b0;
        t_jmp;
        t_rd8;
        t_st8;
        t_w16;
        t_jsr;
        t_rmw_clr;
        t_imm;
        t_refuse;
        print_verdict;
    end
endmodule
